// >>> shared/aau_pkg.sv
package aau_pkg;
  localparam int unsigned WORD_W = 12;
  localparam int unsigned SIGN_BIT = 11;
  // operation codes presented by the sequencer
  typedef enum logic [2:0]
  {
    AAU_OP_NONE = 3'b000,
    AAU_OP_ISZ = 3'b001,
    AAU_OP_AND = 3'b010,
    AAU_OP_TAD = 3'b011,
    AAU_OP_OPR1 = 3'b100,
    AAU_OP_LOAD = 3'b101
  } aau_op_t;
  // bit positions within the eight group-one operate bits
  localparam int unsigned OPR_CLA_BIT = 7;
  localparam int unsigned OPR_CLL_BIT = 6;
  localparam int unsigned OPR_CMA_BIT = 5;
  localparam int unsigned OPR_CML_BIT = 4;
  localparam int unsigned OPR_IAC_BIT = 0;
  localparam logic [11:0] IAC_CODE = 12'hE01; // octal 7001
  // operate event times
  localparam logic [1:0] EVT_CLEAR = 2'h1;
  localparam logic [1:0] EVT_CMA = 2'h2;
  localparam logic [1:0] EVT_IAC = 2'h3;
  localparam logic [11:0] AC_RESET = 12'h000;
  localparam logic LINK_RESET = 1'b0;
endpackage

// >>> rtl/aau_adder.sv
`timescale 1ns/1ps
// plain twelve-bit adder with carry out of the sign bit
module aau_adder #(
  parameter int unsigned W = 12
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  output logic [W-1:0] sum,
  output logic cout
);
  logic [W:0] full;
  // no end-around carry: the carry leaves here and nowhere else
  always_comb
  begin
    full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    sum = full[W-1:0];
    cout = full[W];
  end
endmodule

// >>> rtl/aau_core.sv
`timescale 1ns/1ps
module aau_core #(
  parameter int unsigned W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire aau_pkg::aau_op_t op,
  input wire logic [W-1:0] mem_rd_data,
  input wire logic [7:0] opr_bits,
  output logic [W-1:0] ac,
  output logic link,
  output logic [W-1:0] mem_wr_data,
  output logic mem_wr,
  output logic skip,
  output logic done
);
  typedef enum logic [1:0]
  {
    AAU_IDLE = 2'b00,
    AAU_EXEC = 2'b01,
    AAU_OPR = 2'b10
  } aau_state_t;

  aau_state_t state;
  aau_pkg::aau_op_t op_q;
  logic [W-1:0] opnd;
  logic [7:0] bits_q;
  logic [1:0] evt;
  logic [W-1:0] add_a;
  logic [W-1:0] add_b;
  logic add_cin;
  logic [W-1:0] add_sum;
  logic add_cout;
  logic last_evt;

  // one shared adder serves tad, isz and iac
  aau_adder #(.W(W)) u_add (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout)
  );

  // operand select: isz increments memory, iac increments ac
  always_comb
  begin
    add_a = ac;
    add_b = {W{1'b0}};
    add_cin = 1'b0;
    if (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_ISZ)
    begin
      add_a = opnd;
      add_cin = 1'b1;
    end
    else if (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_TAD)
    begin
      add_b = opnd;
    end
    else if (state == AAU_OPR && evt == aau_pkg::EVT_IAC)
    begin
      add_cin = bits_q[aau_pkg::OPR_IAC_BIT];
    end
  end

  assign last_evt = (evt == aau_pkg::EVT_IAC);

  // sequencer: exec ops take one cycle, operate walks event times
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= AAU_IDLE;
      op_q <= aau_pkg::AAU_OP_NONE;
      opnd <= '0;
      bits_q <= 8'h00;
      evt <= 2'h0;
    end
    else
    begin
      case (state)
        AAU_IDLE:
        begin
          if (start)
          begin
            op_q <= op;
            opnd <= mem_rd_data;
            bits_q <= opr_bits;
            evt <= aau_pkg::EVT_CLEAR;
            state <= (op == aau_pkg::AAU_OP_OPR1) ? AAU_OPR : AAU_EXEC;
          end
        end
        AAU_EXEC:
        begin
          state <= AAU_IDLE;
        end
        AAU_OPR:
        begin
          // complement always precedes increment
          evt <= evt + 2'h1;
          if (last_evt)
          begin
            state <= AAU_IDLE;
          end
        end
        default:
        begin
          state <= AAU_IDLE;
        end
      endcase
    end
  end

  // accumulator; isz falls to the default arm so ac is kept
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ac <= aau_pkg::AC_RESET;
    end
    else if (state == AAU_EXEC)
    begin
      case (op_q)
        aau_pkg::AAU_OP_AND: ac <= ac & opnd;
        // truncated sum even on overflow
        aau_pkg::AAU_OP_TAD: ac <= add_sum;
        aau_pkg::AAU_OP_LOAD: ac <= opnd;
        default: ac <= ac;
      endcase
    end
    else if (state == AAU_OPR)
    begin
      if (evt == aau_pkg::EVT_CLEAR && bits_q[aau_pkg::OPR_CLA_BIT])
      begin
        ac <= '0;
      end
      else if (evt == aau_pkg::EVT_CMA && bits_q[aau_pkg::OPR_CMA_BIT])
      begin
        ac <= ~ac; // sign bit flips with value
      end
      else if (evt == aau_pkg::EVT_IAC)
      begin
        ac <= add_sum;
      end
    end
  end

  // link: tad and iac carry out of sign toggles it, isz carry does not, never feeds back in
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link <= aau_pkg::LINK_RESET;
    end
    else if (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_TAD)
    begin
      link <= link ^ add_cout;
    end
    else if (state == AAU_OPR)
    begin
      if (evt == aau_pkg::EVT_CLEAR && bits_q[aau_pkg::OPR_CLL_BIT])
      begin
        link <= 1'b0;
      end
      else if (evt == aau_pkg::EVT_CMA && bits_q[aau_pkg::OPR_CML_BIT])
      begin
        link <= ~link;
      end
      else if (evt == aau_pkg::EVT_IAC)
      begin
        link <= link ^ add_cout; // iac carry also toggles link
      end
    end
  end

  // memory write-back and skip for isz
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_wr <= 1'b0;
      mem_wr_data <= '0;
      skip <= 1'b0;
    end
    else
    begin
      mem_wr <= 1'b0;
      skip <= 1'b0;
      if (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_ISZ)
      begin
        mem_wr <= 1'b1;
        mem_wr_data <= add_sum;
        skip <= (add_sum == '0);
      end
    end
  end

  // completion pulse, one cycle after the last step
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= (state == AAU_EXEC) || (state == AAU_OPR && last_evt);
    end
  end

  sequence isz_req_s;
    state == AAU_IDLE && start && op == aau_pkg::AAU_OP_ISZ;
  endsequence

  // operand is only valid with start, so look back to the request edge
  sequence isz_wb_s;
    ##2 mem_wr && mem_wr_data == 12'($past(mem_rd_data, 2) + 12'h001);
  endsequence

  isz_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    isz_req_s |-> isz_wb_s)
    else $error("isz write-back wrong");

  // only an all-ones word wraps to zero and skips
  isz_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    isz_req_s
    |-> ##2 skip == ($past(mem_rd_data, 2) == 12'hfff))
    else $error("isz skip wrong");

  isz_keeps_ac_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    isz_req_s |-> ##2 $stable(ac))
    else $error("isz changed accumulator");

  and_result_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_IDLE && start && op == aau_pkg::AAU_OP_AND)
    |-> ##2 ac == ($past(ac, 2) & $past(mem_rd_data, 2)))
    else $error("and result wrong");

  tad_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_IDLE && start && op == aau_pkg::AAU_OP_TAD)
    |-> ##2 ac == 12'($past(ac, 2) + $past(mem_rd_data, 2)))
    else $error("tad sum wrong");

  tad_link_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_TAD)
    |=> link == ($past(link) ^ ({1'b0, $past(ac)} + {1'b0, $past(opnd)}
    > 13'hfff)))
    else $error("link not toggled by carry");

  tad_low_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_EXEC && op_q == aau_pkg::AAU_OP_TAD)
    |=> ac[10:0] == 11'($past(ac) + $past(opnd)))
    else $error("low bits of sum wrong");

  negate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_IDLE && start && op == aau_pkg::AAU_OP_OPR1
    && opr_bits == 8'h21)
    |-> ##4 ac == 12'(12'h000 - $past(ac, 4)))
    else $error("negate wrong");

  iac_event_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == AAU_OPR && evt == aau_pkg::EVT_IAC
    && bits_q[aau_pkg::OPR_IAC_BIT])
    |=> ac == 12'($past(ac) + 12'h001))
    else $error("iac did not add one");
endmodule

// >>> bench/aau_mem_model.sv
`timescale 1ns/1ps
// core memory stand-in: sixteen words, immediate read, strobed write
module aau_mem_model (
  input wire logic clk_sys,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic [11:0] wr_data,
  output logic [11:0] rd_data
);
  logic [11:0] words [16];
  // write lands on the edge after the strobe, so the next read sees it
  always @(posedge clk_sys)
  begin
    if (wr)
    begin
      words[addr] <= wr_data;
    end
  end
  assign rd_data = words[addr];
endmodule

// >>> bench/accumulator_arithmetic_unit_tb_top.sv
`timescale 1ns/1ps
module accumulator_arithmetic_unit_tb_top;
  logic clk_sys;
  logic rst_b;
  logic start;
  aau_pkg::aau_op_t op;
  logic [3:0] addr;
  logic [7:0] opr_bits;
  logic [11:0] rd_data;
  logic [11:0] ac;
  logic [11:0] wr_data;
  logic link;
  logic mem_wr;
  logic skip;
  logic done;
  logic sk;
  logic l0;
  logic mw;
  int bad_count;
  int n_checks;
  aau_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .op(op),
    .mem_rd_data(rd_data), .opr_bits(opr_bits), .ac(ac), .link(link),
    .mem_wr_data(wr_data), .mem_wr(mem_wr), .skip(skip), .done(done));
  aau_mem_model mem (.clk_sys(clk_sys), .addr(addr), .wr(mem_wr),
    .wr_data(wr_data), .rd_data(rd_data));
  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one request; waits a bounded time for done and keeps the skip pulse
  task automatic run(input aau_pkg::aau_op_t o, input logic [3:0] a,
    input logic [7:0] b);
    int i;
    @(posedge clk_sys);
    start <= 1'b1;
    op <= o;
    addr <= a;
    opr_bits <= b;
    @(posedge clk_sys);
    start <= 1'b0;
    for (i = 0; i < 8 && done !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    sk = skip;
    mw = mem_wr;
    chk({11'h000, done}, 12'h001);
  endtask
  task automatic ld(input logic [11:0] v);
    mem.words[0] = v;
    run(aau_pkg::AAU_OP_LOAD, 4'h0, 8'h00);
  endtask
  task automatic neg(input logic [11:0] v);
    ld(v);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'h21);
  endtask
  task automatic t_isz();
    ld(12'h123);
    mem.words[1] = 12'hffe;
    run(aau_pkg::AAU_OP_ISZ, 4'h1, 8'h00);
    chk(wr_data, 12'hfff);
    chk({11'h000, sk}, 12'h000);
    chk({11'h000, mw}, 12'h001);
    run(aau_pkg::AAU_OP_ISZ, 4'h1, 8'h00);
    chk(wr_data, 12'h000);
    chk({11'h000, sk}, 12'h001);
    chk(ac, 12'h123);
    chk({11'h000, link}, 12'h000);
    $display("isz test done");
  endtask
  task automatic t_and();
    ld(12'h3c5);
    mem.words[2] = 12'h0ff;
    run(aau_pkg::AAU_OP_AND, 4'h2, 8'h00);
    chk(ac, 12'h0c5);
    chk({11'h000, mw}, 12'h000);
    $display("and test done");
  endtask
  task automatic t_tad();
    ld(12'h7ff);
    l0 = link;
    mem.words[3] = 12'h001;
    mem.words[4] = 12'h800;
    run(aau_pkg::AAU_OP_TAD, 4'h3, 8'h00);
    chk(ac, 12'h800);
    chk({11'h000, link}, {11'h000, l0});
    run(aau_pkg::AAU_OP_TAD, 4'h4, 8'h00);
    chk(ac, 12'h000);
    chk({11'h000, link}, {11'h000, ~l0});
    $display("add test done");
  endtask
  // negation over a table, then clear ahead of complement
  task automatic t_neg();
    logic [11:0] v [4];
    v = '{12'h005, 12'h001, 12'h800, 12'h7ff};
    foreach (v[i])
    begin
      neg(v[i]);
      chk(ac, ~v[i] + 12'h001);
    end
    ld(12'h5a5);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'ha0);
    chk(ac, 12'hfff);
    $display("negate test done");
  endtask
  // operate bits: increment alone, complement alone, link clear then flip, link clear alone
  task automatic t_opr();
    ld(12'hfff);
    l0 = link;
    run(aau_pkg::AAU_OP_OPR1, 4'h0, aau_pkg::IAC_CODE[7:0]);
    chk(ac, 12'h000);
    chk({11'h000, link}, {11'h000, ~l0});
    ld(12'h005);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'h20);
    chk(ac, 12'hffa);
    chk({11'h000, ac[aau_pkg::SIGN_BIT]}, 12'h001);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'h50);
    chk({11'h000, link}, 12'h001);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'h40);
    chk({11'h000, link}, 12'h000);
    chk(ac, 12'hffa);
    $display("operate test done");
  endtask
  task automatic t_sub();
    logic [11:0] p [3][2];
    p = '{'{12'h005, 12'h003}, '{12'h003, 12'h005}, '{12'hf00, 12'h0ff}};
    foreach (p[i])
    begin
      neg(p[i][1]);
      mem.words[5] = p[i][0];
      run(aau_pkg::AAU_OP_TAD, 4'h5, 8'h00);
      chk(ac, p[i][0] - p[i][1]);
    end
    $display("subtract test done");
  endtask
  // reset between requests clears accumulator and link, then a load works again
  task automatic t_rst();
    ld(12'h0a5);
    run(aau_pkg::AAU_OP_OPR1, 4'h0, 8'h50);
    chk({11'h000, link}, 12'h001);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(ac, 12'h000);
    chk({11'h000, link}, 12'h000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    ld(12'h00f);
    chk(ac, 12'h00f);
    $display("reset test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, 4000 cycles, far beyond the under 150 cycles the tests need
  initial
  begin
    #20000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    rst_b = 1'b0;
    start = 1'b0;
    op = aau_pkg::AAU_OP_NONE;
    addr = 4'h0;
    opr_bits = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk(ac, 12'h000);
    t_isz();
    t_and();
    t_tad();
    t_neg();
    t_opr();
    t_sub();
    t_rst();
    give_verdict();
  end
endmodule
